/* File: verilog/flush_pkg.sv */
// Constants, field layouts and state codes for the cache set flush engine.
// Assumes a control-space byte address on the register bus and an external tag store.
//
// Functional notes
// R1: write to map 0xA with data bits 01 starts a context-match flush of the set.
// R2: context match: block is a user block and its context equals context register.
// R3: data bits 10 start a page-match flush; address gives page bits and set index.
// R4: page match compares virtual bits 27..14; bit 13 is implied by the set index.
// R5: page and segment match also need supervisor tag set or context equal.
// R6: data bits 11 start a segment-match flush comparing virtual bits 27..17.
// R7: matching valid modified blocks are written back, then matching valid blocks invalidated.
// R8: failed write-back translation raises an error interrupt, flush still completes.
// R9: write-backs carry no protection check and no accessed or modified update.
// R10: non-matching or invalid blocks keep their tags and get no write-back.
package flush_pkg;
   // ******************************
   // control-space decode
   // ******************************
   localparam logic [3:0] MAP_FLUSH = 4'hA;
   localparam logic [3:0] MAP_CTX = 4'h3;
   localparam logic [3:0] MAP_STAT = 4'h4;
   localparam logic [1:0] FT_CTX = 2'h1;
   localparam logic [1:0] FT_PAGE = 2'h2;
   localparam logic [1:0] FT_SEG = 2'h3;
   localparam int MAP_HI = 31;
   localparam int MAP_LO = 28;

   // ******************************
   // cache geometry (16 KB, 16-byte blocks)
   // ******************************
   localparam int IDX_W = 10;
   localparam int IDX_LO = 4;
   localparam int SET_W = 2;
   localparam int VA_W = 28;
   localparam int PAGE_LO = 14;
   localparam int SEG_LO = 17;
   localparam int CTX_W = 3;

   // ******************************
   // tag word layout
   // ******************************
   localparam int VT_W = 14;
   localparam int TAG_W = 20;
   localparam int TG_CTX_LO = 14;
   localparam int TG_SUP = 17;
   localparam int TG_MOD = 18;
   localparam int TG_VAL = 19;

   // ******************************
   // status bits and reset values
   // ******************************
   localparam int ST_BUSY = 0;
   localparam int ST_WBERR = 1;
   localparam logic [CTX_W-1:0] CTX_RST = 3'h0;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RD   = 3'b001,
      S_CHK  = 3'b010,
      S_WB   = 3'b011,
      S_INV  = 3'b100,
      S_NEXT = 3'b101,
      S_DONE = 3'b110
   } state_type;
endpackage

/* File: verilog/cache_set_flush.sv */
// Flush engine for one set of a virtually addressed write-back cache.
// Assumes a tag store with one-cycle read latency and a write-back port with an ack pulse.
`timescale 1ns/1ps
module cache_set_flush (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [31:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // tag store
   output logic [flush_pkg::IDX_W-1:0] tag_addr,
   input wire logic [flush_pkg::TAG_W-1:0] tag_rdata,
   output logic tag_we,
   output logic [flush_pkg::TAG_W-1:0] tag_wdata,
   // write-back path
   output logic wb_req,
   output logic [flush_pkg::VA_W-1:0] wb_vaddr,
   output logic [flush_pkg::IDX_W-1:0] wb_index,
   input wire logic wb_ack,
   input wire logic wb_fail,
   // error interrupt
   output logic wb_err_int
);
   import flush_pkg::*;

   // ******************************
   // state
   // ******************************
   state_type state_ff, nxt_state;
   logic [CTX_W-1:0] ctx_ff, nxt_ctx;
   logic err_ff, nxt_err;
   logic [1:0] type_ff, nxt_type;
   logic [VA_W-1:0] cmd_ff, nxt_cmd;
   logic [SET_W-1:0] blk_ff, nxt_blk;
   logic [TAG_W-1:0] tag_ff, nxt_tag;
   logic rd_pend_ff, nxt_rd_pend;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wb_req_ff, nxt_wb_req;
   logic [VA_W-1:0] wb_va_ff, nxt_wb_va;
   logic [IDX_W-1:0] taddr_ff, nxt_taddr;
   logic tag_we_ff, nxt_tag_we;
   logic [TAG_W-1:0] twdata_ff, nxt_twdata;

   logic [3:0] map;
   logic flush_hit;
   logic match;
   logic crit_ctx;
   logic [VA_W-1:0] blk_va;
   logic [IDX_W-1:0] set_base;
   logic err_clr;
   logic rd_wait;
   logic flush_wait;

   // ******************************
   // helper functions
   // ******************************
   // context tag of a block against the context register
   function automatic logic ctx_equal(
      input logic [TAG_W-1:0] tag,
      input logic [CTX_W-1:0] ctx
   );
      return tag[TG_CTX_LO+CTX_W-1:TG_CTX_LO] == ctx;
   endfunction

   // first tag index of the set named by a command address
   function automatic logic [IDX_W-1:0] set_start(
      input logic [VA_W-1:0] va
   );
      return {va[IDX_LO+IDX_W-1:IDX_LO+SET_W], {SET_W{1'b0}}};
   endfunction

   // virtual block address rebuilt from the tag and its index
   function automatic logic [VA_W-1:0] virt_addr(
      input logic [TAG_W-1:0] tag,
      input logic [IDX_W-1:0] idx
   );
      return {tag[VT_W-1:0], idx, 4'h0};
   endfunction

   // tag with valid and modified dropped, all other fields kept
   function automatic logic [TAG_W-1:0] invalid_tag(
      input logic [TAG_W-1:0] tag
   );
      logic [TAG_W-1:0] t;
      t = tag;
      t[TG_VAL] = 1'b0;
      t[TG_MOD] = 1'b0;
      return t;
   endfunction

   assign map = address[MAP_HI:MAP_LO];
   assign flush_hit = write && (map == MAP_FLUSH) && (writedata[1:0] != 2'h0);
   assign set_base = set_start(cmd_ff);
   assign err_clr = write && (map == MAP_STAT) && writedata[ST_WBERR];

   // ******************************
   // match decision on the fetched tag
   // ******************************
   always_comb begin
      blk_va = virt_addr(tag_rdata, taddr_ff);
      crit_ctx = tag_rdata[TG_SUP] || ctx_equal(tag_rdata, ctx_ff); // R5
      case (type_ff)
         FT_CTX: begin
            match = !tag_rdata[TG_SUP] && ctx_equal(tag_rdata, ctx_ff); // R2
         end
         FT_PAGE: begin
            match = (blk_va[VA_W-1:PAGE_LO] == cmd_ff[VA_W-1:PAGE_LO]) && crit_ctx; // R4
         end
         FT_SEG: begin
            match = (blk_va[VA_W-1:SEG_LO] == cmd_ff[VA_W-1:SEG_LO]) && crit_ctx; // R6
         end
         default: begin
            match = 1'b0;
         end
      endcase
   end

   // ******************************
   // register bus: context register and read data
   // ******************************
   always_comb begin
      nxt_ctx = ctx_ff;
      nxt_rd_pend = rd_pend_ff;
      nxt_rdata = rdata_ff;

      // register reads take two cycles so read data comes from a flip-flop
      if (read && !rd_pend_ff) begin
         nxt_rd_pend = 1'b1;
         case (map)
            MAP_CTX: begin
               nxt_rdata = {29'h0, ctx_ff};
            end
            MAP_STAT: begin
               nxt_rdata = {30'h0, err_ff, (state_ff != S_IDLE)};
            end
            default: begin
               nxt_rdata = 32'h0;
            end
         endcase
      end else if (read) begin
         nxt_rd_pend = 1'b0;
      end

      if (write && (map == MAP_CTX)) begin
         nxt_ctx = writedata[CTX_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctx_ff <= CTX_RST;
         rd_pend_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         ctx_ff <= nxt_ctx;
         rd_pend_ff <= nxt_rd_pend;
         rdata_ff <= nxt_rdata;
      end
   end

   // ******************************
   // flush engine next-state logic
   // ******************************
   // per block: read, check, then write-back and invalidate only on a match;
   // the bus write stays stalled until the whole set has been walked
   always_comb begin
      nxt_state = state_ff;
      nxt_err = err_ff;
      nxt_type = type_ff;
      nxt_cmd = cmd_ff;
      nxt_blk = blk_ff;
      nxt_tag = tag_ff;
      nxt_wb_req = wb_req_ff;
      nxt_wb_va = wb_va_ff;
      nxt_taddr = taddr_ff;
      nxt_tag_we = 1'b0;
      nxt_twdata = twdata_ff;

      // write one to clear; a same-cycle failure below still sets the flag
      if (err_clr) begin
         nxt_err = 1'b0;
      end

      case (state_ff)
         S_IDLE: begin
            if (flush_hit) begin // R1 R3 R6
               nxt_type = writedata[1:0];
               nxt_cmd = address[VA_W-1:0];
               nxt_blk = '0;
               nxt_taddr = set_start(address[VA_W-1:0]);
               nxt_state = S_RD;
            end
         end
         S_RD: begin
            nxt_state = S_CHK;
         end
         S_CHK: begin
            nxt_tag = tag_rdata;
            if (tag_rdata[TG_VAL] && match) begin
               if (tag_rdata[TG_MOD]) begin // R7
                  // only the address goes out: no protection or mmu bit update
                  nxt_wb_req = 1'b1; // R9
                  nxt_wb_va = blk_va;
                  nxt_state = S_WB;
               end else begin
                  nxt_state = S_INV;
               end
            end else begin
               nxt_state = S_NEXT; // R10
            end
         end
         S_WB: begin
            if (wb_ack) begin
               nxt_wb_req = 1'b0;
               if (wb_fail) begin
                  nxt_err = 1'b1; // R8
               end
               nxt_state = S_INV;
            end
         end
         S_INV: begin
            nxt_tag_we = 1'b1; // R7
            nxt_twdata = invalid_tag(tag_ff);
            nxt_state = S_NEXT;
         end
         S_NEXT: begin
            if (blk_ff == {SET_W{1'b1}}) begin
               nxt_state = S_DONE;
            end else begin
               nxt_blk = blk_ff + 1'b1;
               nxt_taddr = set_base | {{(IDX_W-SET_W){1'b0}}, blk_ff + 1'b1};
               nxt_state = S_RD;
            end
         end
         S_DONE: begin
            nxt_state = S_IDLE;
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   // ******************************
   // registers
   // ******************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= S_IDLE;
         err_ff <= 1'b0;
         type_ff <= 2'h0;
         cmd_ff <= '0;
         blk_ff <= '0;
         tag_ff <= '0;
         wb_req_ff <= 1'b0;
         wb_va_ff <= '0;
         taddr_ff <= '0;
         tag_we_ff <= 1'b0;
         twdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         err_ff <= nxt_err;
         type_ff <= nxt_type;
         cmd_ff <= nxt_cmd;
         blk_ff <= nxt_blk;
         tag_ff <= nxt_tag;
         wb_req_ff <= nxt_wb_req;
         wb_va_ff <= nxt_wb_va;
         taddr_ff <= nxt_taddr;
         tag_we_ff <= nxt_tag_we;
         twdata_ff <= nxt_twdata;
      end
   end

   // ******************************
   // outputs
   // ******************************
   // a read waits one cycle for its registered data
   assign rd_wait = read && !rd_pend_ff;
   // a flush write is held until its set is fully processed
   assign flush_wait = flush_hit && (state_ff != S_DONE);
   assign waitrequest = rd_wait || flush_wait;
   assign readdata = rdata_ff;
   assign tag_addr = taddr_ff;
   assign tag_we = tag_we_ff;
   assign tag_wdata = twdata_ff;
   assign wb_req = wb_req_ff;
   assign wb_vaddr = wb_va_ff;
   assign wb_index = taddr_ff;
   assign wb_err_int = err_ff; // R8
endmodule

/* File: test/flush_monitor.sv */
// port checker for the cache set flush engine
// sees only the top ports; bound to every instance below
`timescale 1ns/1ps
module flush_monitor import flush_pkg::*; (
   input wire logic mclk, rstn, read, write, waitrequest, tag_we,
   input wire logic wb_req, wb_ack, wb_fail, wb_err_int,
   input wire logic [31:0] address, writedata,
   input wire logic [IDX_W-1:0] tag_addr, wb_index,
   input wire logic [TAG_W-1:0] tag_rdata, tag_wdata,
   input wire logic [VA_W-1:0] wb_vaddr
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic clr;
   assign clr = write && address[31:28] == MAP_STAT && writedata[ST_WBERR];
   chk_wb_hold: assert property (
      wb_req && !wb_ack |=> wb_req && $stable(wb_vaddr)) else $error("wb dropped");
   chk_we_pulse: assert property (
      tag_we |=> !tag_we) else $error("tag write too long");
   chk_inv_bits: assert property (
      tag_we |-> tag_rdata[TG_VAL] && !tag_wdata[TG_VAL] && !tag_wdata[TG_MOD]
      && tag_wdata[TG_SUP:0] == tag_rdata[TG_SUP:0]) else $error("bad invalidate");
   chk_wb_addr: assert property (
      wb_req |-> tag_rdata[TG_VAL] && tag_rdata[TG_MOD] && wb_index == tag_addr
      && wb_vaddr == {tag_rdata[VT_W-1:0], tag_addr, 4'h0}) else $error("bad wb");
   chk_err_set: assert property (
      wb_req && wb_ack && wb_fail |=> wb_err_int) else $error("error not raised");
   chk_err_sticky: assert property (
      wb_err_int && !clr |=> wb_err_int) else $error("error lost");
   chk_busy_only: assert property (
      tag_we || wb_req |-> write && waitrequest) else $error("work while idle");
   chk_wb_then_inv: assert property (
      wb_req && wb_ack |-> ##[1:2] tag_we) else $error("no invalidate");
   cov_inv: cover property (tag_we);
   cov_wb_fail: cover property (wb_req && wb_ack && wb_fail);
   cov_read: cover property (read && !waitrequest);
endmodule

bind cache_set_flush flush_monitor flush_monitor_inst (.*);

/* File: test/flush_partner.sv */
// tag store and write-back responder facing the flush engine
// one-cycle tag read latency; fail_wb makes write-backs fail
`timescale 1ns/1ps
module flush_partner import flush_pkg::*; (
   input wire logic mclk,
   input wire logic [IDX_W-1:0] tag_addr,
   output logic [TAG_W-1:0] tag_rdata,
   input wire logic tag_we,
   input wire logic [TAG_W-1:0] tag_wdata,
   input wire logic wb_req,
   output logic wb_ack = 1'b0,
   output logic wb_fail = 1'b0,
   input wire logic fail_wb
);
   logic [TAG_W-1:0] mem [0:(1<<IDX_W)-1];
   int dly = 0;
   always @(posedge mclk) begin
      tag_rdata <= mem[tag_addr];
      if (tag_we) mem[tag_addr] <= tag_wdata;
      wb_ack <= 1'b0;
      wb_fail <= ~wb_fail;
      if (wb_req && !wb_ack) begin
         if (dly == 0) begin
            wb_ack <= 1'b1;
            wb_fail <= fail_wb;
            dly = $urandom_range(3);
         end else dly--;
      end
   end
endmodule

/* File: test/tb.sv */
// self-checking bench for the cache set flush engine
// drives the avalon port; the partner model holds the tags
`timescale 1ns/1ps
module tb;
   import flush_pkg::*;
   logic mclk = 0, rstn = 0, read = 0, write = 0, fail_wb = 0;
   logic [31:0] address = '0, writedata = '0, readdata, r;
   logic waitrequest, tag_we, wb_req, wb_ack, wb_fail, wb_err_int;
   logic [IDX_W-1:0] tag_addr, wb_index;
   logic [TAG_W-1:0] tag_rdata, tag_wdata;
   logic [VA_W-1:0] wb_vaddr;
   logic [29:0] tq[$];
   logic [27:0] wq[$];
   int n_fail = 0, n_tests = 0, nwb = 0;
   cache_set_flush cache_set_flush_inst (.*);
   flush_partner flush_partner_inst (.*);
   initial forever #10 mclk = ~mclk;
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      int k;
      @(posedge mclk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (waitrequest !== 1'b0 && k < 400);
      r = readdata;
      if (waitrequest !== 1'b0) begin
         n_fail++;
         test_done();
      end else begin
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   task automatic flush(input logic [1:0] ft, input logic [2:0] ctx);
      logic [31:0] a;
      logic [TAG_W-1:0] t;
      logic [IDX_W-1:0] ix;
      logic m;
      a = {MAP_FLUSH, 22'($urandom), 6'h0};
      for (int j = 0; j < 4; j++) begin
         ix = {a[13:6], 2'(j)};
         t = TAG_W'($urandom);
         if ($urandom % 2) t[13:0] = {a[27:17], 3'($urandom)};
         if ($urandom % 2) t[16:14] = ctx;
         flush_partner_inst.mem[ix] = t;
         m = t[16:14] == ctx || t[TG_SUP];
         if (ft == FT_CTX) m = !t[TG_SUP] && t[16:14] == ctx;
         if (ft == FT_PAGE) m = m && t[13:0] == a[27:14];
         if (ft == FT_SEG) m = m && t[13:3] == a[27:17];
         m = m && t[TG_VAL] && ft != 2'h0;
         nwb += int'(m && t[TG_MOD]);
         if (m && t[TG_MOD]) wq.push_back({t[13:0], ix, 4'h0});
         if (m) tq.push_back({ix, t & 20'h3FFFF});
      end
      bus(1'b1, a, {30'($urandom), ft});
   endtask
   always @(posedge mclk) begin
      if (tag_we === 1'b1)
         chk({tag_addr, tag_wdata} === tq.pop_front(), "tag write");
      if (wb_req === 1'b1 && wb_ack === 1'b1)
         chk(wb_vaddr === wq.pop_front(), "write-back address");
   end
   task automatic stat(input logic [31:0] e);
      bus(1'b0, {MAP_STAT, 28'h0}, 32'h0);
      chk(r === e && wb_err_int === e[ST_WBERR], "status");
   endtask
   initial begin
      logic [2:0] ctx;
      void'($urandom(67251));
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 48; i++) begin
         ctx = $urandom;
         bus(1'b1, {MAP_CTX, 28'h0}, {29'h0, ctx});
         if (i == 1) begin
            bus(1'b0, {MAP_CTX, 28'h0}, 32'h0);
            chk(r === {29'h0, ctx}, "context register");
         end
         if (i == 40) stat(32'h0);
         if (i == 40) nwb = 0;
         fail_wb <= i >= 40;
         flush(2'(i % 4), ctx);
      end
      stat({30'h0, nwb > 0, 1'b0});
      bus(1'b1, {MAP_STAT, 28'h0}, 32'h2);
      stat(32'h0);
      bus(1'b0, 32'h5000_0000, 32'h0);
      chk(r === 32'h0, "unmapped read");
      chk(tq.size() == 0 && wq.size() == 0, "missing results");
      test_done();
   end
endmodule
